// [sprf_top.v]
// Serial host port with conversion ready flag
// Overview of operation
// RULE1 - Active low chip select selects device
// RULE2 - Chip select edges frame each transfer
// RULE3 - Select tied low gives three-wire mode
// RULE4 - Ready low while unread result waits
// RULE5 - Ready high after data read completes
// RULE6 - Ready high before next result update
// RULE7 - Ready low when calibration finishes
// RULE8 - Ready held low until mode written
// RULE9 - Output shifter loads from any register
// RULE10 - Input bits captured into shift register
// RULE11 - Input word goes to selected register
// RULE12 - Continuous or gated shift clock accepted
// RULE13 - Reset returns device to power-on state; the register memory is not reset and keeps its contents
// RULE14 - Output released, clock ignored, when deselected
`timescale 1ns/1ns
`include "sprf_map.vh"
`default_nettype none
module sprf_top #(
  parameter DW = `SPRF_DATA_W,
  parameter AW = `SPRF_REG_AW
) (
  input  wire          core_clk,    // Core clock
  input  wire          sys_rst,     // Synchronous reset, high
  input  wire          cs_n,        // Chip select pin, low
  input  wire          sclk,        // Shift clock pin
  input  wire          din,         // Serial data in pin
  output reg           dout,        // Serial data out
  output reg           dout_oe,     // Serial out enable, high drives
  output reg           rdy_n,       // Ready flag, low
  input  wire          conv_done,   // Pulse: new result from converter
  input  wire [DW-1:0] conv_data,   // Result word with pulse
  input  wire          conv_pre,    // Pulse: update is about to happen
  input  wire          cal_done,    // Pulse: calibration finished
  output reg  [2:0]    mode_bits,   // Current mode field
  output reg           mode_wr      // Pulse: mode register written
);
  // ==========================================
  // Pin synchronisers
  reg [1:0] cs_s_r;
  reg [1:0] sclk_s_r;
  reg [1:0] din_s_r;
  reg       sclk_d_r;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cs_s_r   <= 2'h3;
      sclk_s_r <= 2'h0; // Idle low, so no false edge follows reset
      din_s_r  <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      cs_s_r   <= {cs_s_r[0], cs_n};
      sclk_s_r <= {sclk_s_r[0], sclk};
      din_s_r  <= {din_s_r[0], din};
      sclk_d_r <= sclk_s_r[1];
    end
  end
  wire cs_act = ~cs_s_r[1]; // RULE1
  // Edges of the sampled shift clock, gated or free-running alike
  wire sclk_fall = sclk_d_r & ~sclk_s_r[1] & cs_act; // RULE12 RULE14
  wire sclk_rise = ~sclk_d_r & sclk_s_r[1] & cs_act; // RULE12 RULE14
  reg  cs_d_r;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cs_d_r <= 1'b0;
    end else begin
      cs_d_r <= cs_act;
    end
  end
  wire frame_start = cs_act & ~cs_d_r; // RULE2
  // ==========================================
  // Transfer state machine
  localparam ST_COMM = 2'h0;
  localparam ST_WR   = 2'h1;
  localparam ST_RD   = 2'h2;
  reg [1:0]    st_r;
  reg [1:0]    st_nxt;
  reg [4:0]    cnt_r;
  reg [DW-1:0] in_sr_r;
  reg [DW-1:0] out_sr_r;
  reg [7:0]    comm_r;
  reg          load_pend_r;
  reg          data_vld_r;
  reg [DW-1:0] data_r;
  wire [DW-1:0] mem_q;
  wire [3:0]    sel = comm_r[`SPRF_COMM_SEL_HI:`SPRF_COMM_SEL_LO];
  wire [4:0]    last_bit = (sel == `SPRF_SEL_DATA) ? 5'h17 : 5'h07;
  wire          byte_done = sclk_rise & (cnt_r == 5'h07);
  wire          word_done = sclk_rise & (cnt_r == last_bit);
  wire [DW-1:0] in_next = {in_sr_r[DW-2:0], din_s_r[1]};
  // Next state
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_COMM: begin
        if (byte_done) begin
          st_nxt = in_next[`SPRF_COMM_RW_BIT] ? ST_RD : ST_WR;
        end
      end
      ST_WR: begin
        if (sclk_rise & (cnt_r == last_bit)) begin
          st_nxt = ST_COMM;
        end
      end
      ST_RD: begin
        if (word_done) begin
          st_nxt = ST_COMM;
        end
      end
      default: st_nxt = ST_COMM;
    endcase
  end
  // Shift registers, counters and register writes
  reg          mem_we_r;
  reg [AW-1:0] mem_wa_r;
  reg [DW-1:0] mem_wd_r;
  reg          data_rd_done_r;
  always @(posedge core_clk) begin
    if (sys_rst) begin // RULE13
      st_r           <= ST_COMM;
      cnt_r          <= 5'h00;
      in_sr_r        <= {DW{1'b0}};
      comm_r         <= `SPRF_COMM_RST;
      mem_we_r       <= 1'b0;
      mem_wa_r       <= {AW{1'b0}};
      mem_wd_r       <= {DW{1'b0}};
      load_pend_r    <= 1'b0;
      data_rd_done_r <= 1'b0;
      mode_bits      <= `SPRF_MD_IDLE;
      mode_wr        <= 1'b0;
    end else begin
      mem_we_r       <= 1'b0;
      load_pend_r    <= 1'b0;
      data_rd_done_r <= 1'b0;
      mode_wr        <= 1'b0;
      if (frame_start) begin // RULE2
        st_r  <= ST_COMM;
        cnt_r <= 5'h00;
      end else begin
        // Without chip select frames, the counter alone keeps alignment
        st_r <= st_nxt; // RULE3
        if (sclk_rise) begin
          in_sr_r <= in_next; // RULE10
          if (byte_done & (st_r == ST_COMM)) begin
            cnt_r       <= 5'h00;
            comm_r      <= in_next[7:0];
            load_pend_r <= in_next[`SPRF_COMM_RW_BIT];
          end else if (cnt_r == last_bit) begin
            cnt_r <= 5'h00;
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
          if ((st_r == ST_WR) & (cnt_r == last_bit)) begin
            mem_we_r <= 1'b1; // RULE11
            mem_wa_r <= sel[AW-1:0];
            mem_wd_r <= in_next;
            if (sel == `SPRF_SEL_MODE) begin
              mode_bits <= in_next[`SPRF_MODE_MD_HI:`SPRF_MODE_MD_LO];
              mode_wr   <= 1'b1;
            end
          end
          if ((st_r == ST_RD) & (cnt_r == last_bit) & (sel == `SPRF_SEL_DATA)) begin
            data_rd_done_r <= 1'b1;
          end
        end
      end
    end
  end
  // ==========================================
  // Register memory for calibration and control words
  sprf_regmem #(
    .DW (DW),
    .AW (AW)
  ) u_mem (
    .core_clk (core_clk),
    .wr_en    (mem_we_r),
    .wr_addr  (mem_wa_r),
    .wr_data  (mem_wd_r),
    .rd_addr  (sel[AW-1:0]),
    .rd_data  (mem_q)
  );
  // ==========================================
  // Data register and ready flag
  reg cal_hold_r;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      data_r     <= {DW{1'b0}};
      data_vld_r <= 1'b0;
      cal_hold_r <= 1'b0;
      rdy_n      <= 1'b1;
    end else begin
      if (conv_done) begin
        data_r <= conv_data;
      end
      if (mode_wr) begin
        cal_hold_r <= 1'b0; // RULE8
      end
      if (cal_done) begin
        cal_hold_r <= 1'b1; // RULE7
      end
      // New result wins over a read finishing in the same cycle
      if (conv_done) begin
        data_vld_r <= 1'b1;
      end else if (data_rd_done_r | conv_pre) begin
        data_vld_r <= 1'b0; // RULE5 RULE6
      end
      rdy_n <= ~(cal_done | (cal_hold_r & ~mode_wr) |
                 (conv_done | (data_vld_r & ~data_rd_done_r & ~conv_pre))); // RULE4
    end
  end
  // ==========================================
  // Output shift register and pin drive
  wire [DW-1:0] rd_word = (sel == `SPRF_SEL_DATA) ? data_r :
                          (sel == `SPRF_SEL_STAT) ? {{(DW-8){1'b0}}, ~rdy_n, 7'h00} :
                          mem_q;
  // Load waits one more cycle for the registered memory read of the new select
  reg load_go_r;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      load_go_r <= 1'b0;
      out_sr_r  <= {DW{1'b0}};
      dout      <= 1'b0;
      dout_oe   <= 1'b0;
    end else begin
      load_go_r <= load_pend_r;
      if (load_go_r) begin
        out_sr_r <= (sel == `SPRF_SEL_DATA) ? rd_word : (rd_word << (DW-8)); // RULE9
      end else if (sclk_fall & (st_r == ST_RD) & (cnt_r != 5'h00)) begin
        // The falling edge that closes the command byte must not shift
        out_sr_r <= {out_sr_r[DW-2:0], 1'b0};
      end
      dout    <= (st_r == ST_RD) ? out_sr_r[DW-1] : 1'b0;
      dout_oe <= cs_act; // RULE14
    end
  end
endmodule
`default_nettype wire

// [sprf_map.vh]
// Constants for the serial port and ready flag block
`ifndef SPRF_MAP_VH
`define SPRF_MAP_VH
// Communications register fields
`define SPRF_COMM_RW_BIT    6
`define SPRF_COMM_SEL_HI    3
`define SPRF_COMM_SEL_LO    0
`define SPRF_COMM_RST       8'h00
// Register select codes
`define SPRF_SEL_COMM       4'h0
`define SPRF_SEL_STAT       4'h0
`define SPRF_SEL_MODE       4'h1
`define SPRF_SEL_DATA       4'h4
// Mode register fields and reset value
`define SPRF_MODE_MD_HI     2
`define SPRF_MODE_MD_LO     0
`define SPRF_MODE_RST       8'h00
// Mode codes for idle, single conversion and continuous conversion
`define SPRF_MD_IDLE        3'h0
`define SPRF_MD_SINGLE      3'h2
`define SPRF_MD_CONT        3'h3
// Register file depth and width
`define SPRF_REG_DEPTH      16
`define SPRF_REG_AW         4
`define SPRF_DATA_W         24
// Link clock sampling
`define SPRF_SYNC_STAGES    2
`endif

// [sprf_regmem.v]
// Small register memory for calibration and control registers
`timescale 1ns/1ns
`default_nettype none
module sprf_regmem #(
  parameter DW = 24,
  parameter AW = 4
) (
  input  wire          core_clk, // Core clock
  input  wire          wr_en,    // Write strobe
  input  wire [AW-1:0] wr_addr,  // Write index
  input  wire [DW-1:0] wr_data,  // Write word
  input  wire [AW-1:0] rd_addr,  // Read index
  output reg  [DW-1:0] rd_data   // Registered read word
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // ==========================================
  // Write and registered read
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// [sprf_props.sv]
// Assertion checker for the serial port and ready flag block
`timescale 1ns/1ns
`default_nettype none
module sprf_props (
  input wire logic       core_clk,  // Core clock
  input wire logic       sys_rst,   // Reset
  input wire logic       cs_n,      // Select
  input wire logic       dout_oe,   // Out enable
  input wire logic       rdy_n,     // Ready
  input wire logic       conv_done, // New result
  input wire logic       conv_pre,  // Update ahead
  input wire logic       cal_done,  // Cal end
  input wire logic [2:0] mode_bits, // Mode
  input wire logic       mode_wr    // Mode write
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========
  // Calibration hold tracker
  logic hold_r;
  // Set by a calibration end, cleared by a mode write
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      hold_r <= 1'b0;
    else if (cal_done)
      hold_r <= 1'b1;
    else if (mode_wr)
      hold_r <= 1'b0;
  end
  sequence quiet_s; cs_n [*4]; endsequence
  sequence held_s; (!cs_n && !sys_rst) [*4]; endsequence
  // ==========
  // Properties
  reset_state_a:
    assert property (disable iff (1'b0) sys_rst |=> rdy_n && !dout_oe && !mode_wr
      && mode_bits == 3'h0) else $error("reset state");
  data_ready_a:
    assert property (conv_done |=> !rdy_n) else $error("ready not low");
  pre_release_a:
    assert property (conv_pre && !conv_done && !cal_done && !hold_r |=> rdy_n)
      else $error("ready not released");
  cal_ready_a:
    assert property (cal_done |=> !rdy_n) else $error("cal ready");
  cal_hold_a:
    assert property (hold_r && !mode_wr |-> !rdy_n) else $error("cal hold");
  select_drive_a:
    assert property (held_s |-> dout_oe) else $error("not driving");
  quiet_release_a:
    assert property (quiet_s |-> !dout_oe) else $error("driving");
  mode_pulse_a:
    assert property (mode_wr |=> !mode_wr) else $error("long pulse");
  mode_change_a:
    assert property ($changed(mode_bits) |-> mode_wr) else $error("stray mode");
endmodule
bind sprf_top sprf_props sprf_props_inst (.core_clk, .sys_rst, .cs_n, .dout_oe,
  .rdy_n, .conv_done, .conv_pre, .cal_done, .mode_bits, .mode_wr);
`default_nettype wire

// [sprf_host.sv]
// Behavioural serial host for the block
`timescale 1ns/1ns
`default_nettype none
module sprf_host (
  output logic     cs_n,   // Select
  output logic     sclk,   // Shift clock
  output logic     din,    // Data out
  input wire logic dout,   // Data in
  input wire logic dout_oe // Block drives
);
  // Idle levels; clock rests low between transfers, which may also run outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Opens or closes a frame
  task automatic frame(input logic on);
    #80 cs_n = !on;
    #80;
  endtask
  // Shifts n bits MSB first, 160 ns period, optional gap per byte
  task automatic xfer(input logic [31:0] tx, input int n, input int gap,
    output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      din = tx[i];
      #80 sclk = 1'b1;
      rx[i] = dout_oe ? dout : ~dout; // Undriven line reads as the inverse of dout
      #80 sclk = 1'b0;
      if (i % 8 == 0)
        #(gap);
    end
    din = ~din; // Released line loses its value
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the serial port and ready flag block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        core_clk, sys_rst, conv_done, conv_pre, cal_done, cs_n, sclk, din;
  logic        dout, dout_oe, rdy_n, mode_wr, tw;
  logic [2:0]  mode_bits;
  logic [23:0] conv_data;
  logic [31:0] rx;
  int          n_fail = 0;
  int          checks = 0;
  // Device and far-side host
  sprf_top sprf_top_inst (.core_clk, .sys_rst, .cs_n, .sclk, .din, .dout, .dout_oe,
    .rdy_n, .conv_done, .conv_data, .conv_pre, .cal_done, .mode_bits, .mode_wr);
  sprf_host sprf_host_inst (.cs_n, .sclk, .din, .dout, .dout_oe);
  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One-cycle strobe: bit0 result, bit1 update, bit2 calibration
  task automatic pulse(input logic [2:0] k);
    {cal_done, conv_pre, conv_done} = k;
    cyc(1);
    {cal_done, conv_pre, conv_done} = 3'h0;
    cyc(1);
  endtask
  // Command byte then n bits in one frame
  task automatic access(input logic [7:0] c, input logic [31:0] w, input int n, input int g);
    if (!tw)
      sprf_host_inst.frame(1'b1);
    sprf_host_inst.xfer({24'h0, c}, 8, g, rx);
    sprf_host_inst.xfer(w, n, g, rx);
    if (!tw)
      sprf_host_inst.frame(1'b0);
    cyc(12);
  endtask
  task automatic t_regs;
    access(8'h01, 32'h3, 8, 400);
    chk(mode_bits, 3'h3);
    access(8'h05, 32'ha5, 8, 0);
    access(8'h45, 32'h0, 8, 0);
    chk(rx[7:0], 8'ha5);
    access(8'h41, 32'h0, 8, 0);
    chk(rx[7:0], 8'h03);
  endtask
  task automatic t_data;
    pulse(3'h1);
    chk(rdy_n, 1'b0);
    access(8'h44, 32'h0, 24, 0);
    chk(rx[23:0], 24'h5a3c96);
    chk(rdy_n, 1'b1);
    pulse(3'h1);
    pulse(3'h2);
    chk(rdy_n, 1'b1);
  endtask
  task automatic t_cal;
    pulse(3'h4);
    pulse(3'h2);
    chk(rdy_n, 1'b0);
    access(8'h01, 32'h2, 8, 0);
    chk(rdy_n, 1'b1);
    sprf_host_inst.xfer(32'h0107, 16, 0, rx);
    cyc(12);
    chk(mode_bits, 3'h2);
  endtask
  task automatic t_wire3;
    tw = 1'b1;
    sprf_host_inst.frame(1'b1);
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    cyc(3);
    chk(mode_bits, 3'h0);
    access(8'h01, 32'h1, 8, 0);
    access(8'h41, 32'h0, 8, 0);
    chk(rx[7:0], 8'h01);
  endtask
  // Main sequence
  initial begin
    {sys_rst, conv_done, conv_pre, cal_done, tw} = 5'h10;
    conv_data = 24'h5a3c96;
    cyc(3);
    sys_rst = 1'b0;
    cyc(3);
    chk(rdy_n, 1'b1);
    t_regs;
    t_data;
    t_cal;
    t_wire3;
    tally_and_finish;
  end
  // Hang guard
  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
